// ===== common/ffe_pkg.sv
package ffe_pkg;

   // Widths and counts
   localparam int unsigned NAXES = 3;
   localparam int unsigned ACC_W = 14;
   localparam int unsigned MAG_W = 13;
   localparam int unsigned CMP_W = 15;
   localparam int unsigned COMMON_W = 7;
   localparam int unsigned ADDR_W = 32;
   localparam int unsigned IDX_W = 8;

   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_CONFIG = 8'h15;
   localparam logic [7:0] IDX_SOURCE = 8'h16;
   localparam logic [7:0] IDX_THRESH = 8'h17;
   localparam logic [7:0] IDX_DEBOUNCE = 8'h18;
   localparam logic [7:0] IDX_IRQ_EN = 8'h2D;
   localparam logic [7:0] IDX_IRQ_ROUTE = 8'h2E;
   localparam logic [7:0] IDX_STATUS = 8'h40;
   localparam logic [7:0] IDX_MASK = 8'h41;
   localparam logic [7:0] IDX_THR_X = 8'h73;
   localparam logic [7:0] IDX_THR_Y = 8'h75;
   localparam logic [7:0] IDX_THR_Z = 8'h77;

   // Configuration fields
   localparam int unsigned CFG_LATCH_BIT = 7;
   localparam int unsigned CFG_OR_BIT = 6;
   localparam int unsigned CFG_XEN_BIT = 3;

   // Source fields: axis n event at 2n+1, polarity at 2n
   localparam int unsigned SRC_EA_BIT = 7;
   localparam int unsigned SRC_RSVD_BIT = 6;

   // Threshold fields
   localparam int unsigned THS_DBCLR_BIT = 7;
   localparam int unsigned THR_XYZ_EN_BIT = 15;
   localparam int unsigned COMMON_SHIFT = 8;

   // Interrupt status fields
   localparam int unsigned STAT_W = 2;
   localparam int unsigned STAT_RISE_BIT = 0;
   localparam int unsigned STAT_FALL_BIT = 1;

   // Reset values
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [7:0] SRC_RST = 8'h00;
   localparam logic [7:0] THS_RST = 8'h00;
   localparam logic [7:0] DEB_RST = 8'h00;
   localparam logic [15:0] THR_RST = 16'h0000;
   localparam logic [1:0] STAT_RST = 2'h0;

   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== logic/ffe_axis_cmp.sv
`timescale 1ns/1ns
module ffe_axis_cmp import ffe_pkg::*; (
   // Sample and threshold
   input wire logic [ACC_W-1:0] sample,
   input wire logic [CMP_W-1:0] threshold,
   input wire logic high_mode,
   // Result
   output logic flag,
   output logic negative
);

   logic [MAG_W-1:0] mag;

   // Magnitude, most negative value saturates
   always_comb begin
      if (sample[ACC_W-1]) begin
         if (sample[MAG_W-1:0] == '0) begin
            mag = '1;
         end else begin
            mag = MAG_W'(~sample[MAG_W-1:0] + 1'b1);
         end
      end else begin
         mag = sample[MAG_W-1:0];
      end
   end

   // Above threshold for high-g, at or below for low-g
   assign flag = high_mode ? ({2'b00, mag} > threshold)
                           : ({2'b00, mag} <= threshold);
   assign negative = sample[ACC_W-1];

endmodule // ffe_axis_cmp

// ===== logic/ffe_top.sv
`timescale 1ns/1ns
module ffe_top import ffe_pkg::*; (
   // Clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // Acceleration samples
   input wire logic sample_valid,
   input wire logic [ACC_W-1:0] accel_x,
   input wire logic [ACC_W-1:0] accel_y,
   input wire logic [ACC_W-1:0] accel_z,
   // AXI4-Lite write address
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   // AXI4-Lite write data
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   // AXI4-Lite write response
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // AXI4-Lite read address
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   // AXI4-Lite read data
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // Event outputs
   output logic event_active_flag,
   output logic int1_o,
   output logic int2_o,
   output logic irq
);

   // Register state
   logic [7:0] cfg_q;
   logic [7:0] ths_q;
   logic [7:0] deb_limit_q;
   logic [15:0] thr_q [NAXES];
   logic irq_en_q;
   logic irq_route_q;
   logic [STAT_W-1:0] stat_q;
   logic [STAT_W-1:0] mask_q;
   logic [7:0] src_q;
   logic [7:0] deb_cnt_q;
   logic ea_prev_q;
   // Bus state
   logic aw_hold_q;
   logic [IDX_W-1:0] aw_idx_q;
   logic aw_ok_q;
   logic w_hold_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   // Detection signals
   logic [NAXES-1:0] axis_en;
   logic [NAXES-1:0] ax_flag;
   logic [NAXES-1:0] ax_neg;
   logic [ACC_W-1:0] ax_data [NAXES];
   logic [CMP_W-1:0] ax_thr [NAXES];
   logic per_axis_sel;
   logic cond;
   logic det;
   logic [7:0] deb_cnt_d;
   logic [7:0] live_src;
   logic [7:0] src_view;
   // Bus decode signals
   logic aw_fire;
   logic w_fire;
   logic do_write;
   logic ar_fire;
   logic [IDX_W-1:0] ar_idx;
   logic ar_in_range;
   logic aw_in_range;
   logic [31:0] rd_word;
   logic rd_ok;
   logic wr_ok;
   logic read_clr;
   logic sample_go;
   assign axis_en = cfg_q[CFG_XEN_BIT +: NAXES];
   assign per_axis_sel = thr_q[0][THR_XYZ_EN_BIT];
   assign ax_data[0] = accel_x;
   assign ax_data[1] = accel_y;
   assign ax_data[2] = accel_z;
   assign sample_go = ce & sample_valid;

   // Per-axis threshold choice, comparison and source fields
   for (genvar g = 0; g < NAXES; g++) begin : g_axis
      assign ax_thr[g] = per_axis_sel
         ? {2'b00, thr_q[g][MAG_W-1:0]}
         : {ths_q[COMMON_W-1:0], 8'h00};
      ffe_axis_cmp u_cmp (
         .sample(ax_data[g]),
         .threshold(ax_thr[g]),
         .high_mode(cfg_q[CFG_OR_BIT]),
         .flag(ax_flag[g]),
         .negative(ax_neg[g])
      );
      assign live_src[2*g+1] = ax_flag[g] & axis_en[g];
      assign live_src[2*g] = ax_flag[g] & ax_neg[g] & axis_en[g];
      assign src_view[2*g+1] = src_q[2*g+1] & axis_en[g];
      assign src_view[2*g] = src_q[2*g] & axis_en[g];
   end

   // Combine enabled axes: AND of low-g or OR of high-g
   always_comb begin
      if (cfg_q[CFG_OR_BIT]) begin
         cond = |(ax_flag & axis_en);
      end else begin
         cond = (axis_en != '0) && (&(ax_flag | ~axis_en));
      end
   end

   // Debounce next count and detection
   always_comb begin
      if (cond) begin
         if (deb_cnt_q >= deb_limit_q) begin
            deb_cnt_d = deb_limit_q;
         end else begin
            deb_cnt_d = 8'(deb_cnt_q + 8'h01);
         end
      end else if (ths_q[THS_DBCLR_BIT]) begin
         deb_cnt_d = 8'h00;
      end else if (deb_cnt_q != 8'h00) begin
         deb_cnt_d = 8'(deb_cnt_q - 8'h01);
      end else begin
         deb_cnt_d = 8'h00;
      end
   end

   assign det = cond && (deb_cnt_d == deb_limit_q);
   assign live_src[SRC_EA_BIT] = det;
   assign live_src[SRC_RSVD_BIT] = 1'b0;
   assign src_view[SRC_EA_BIT] = src_q[SRC_EA_BIT];
   assign src_view[SRC_RSVD_BIT] = 1'b0;

   // Debounce counter, advanced once per sample
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         deb_cnt_q <= DEB_RST;
      end else if (sample_go) begin
         deb_cnt_q <= deb_cnt_d;
      end
   end

   // Source register: real-time, or held until read
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         src_q <= SRC_RST;
      end else if (ce) begin
         if (sample_valid && (!cfg_q[CFG_LATCH_BIT] ||
             !src_q[SRC_EA_BIT] || read_clr)) begin
            src_q <= live_src;
         end else if (read_clr) begin
            src_q <= SRC_RST;
         end
      end
   end

   // Read of source clears held flags
   assign read_clr = ar_fire && ar_in_range && (ar_idx == IDX_SOURCE) &&
                     cfg_q[CFG_LATCH_BIT];

   // Active flag out, and its routing onto the two event pins
   assign event_active_flag = src_q[SRC_EA_BIT];
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         int1_o <= 1'b0;
         int2_o <= 1'b0;
      end else if (ce) begin
         int1_o <= src_q[SRC_EA_BIT] & irq_en_q & irq_route_q;
         int2_o <= src_q[SRC_EA_BIT] & irq_en_q & ~irq_route_q;
      end
   end

   // Sticky status: set wins over write-one-to-clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ea_prev_q <= 1'b0;
         stat_q <= STAT_RST;
      end else if (ce) begin
         ea_prev_q <= src_q[SRC_EA_BIT];
         for (int i = 0; i < STAT_W; i++) begin
            if ((i == STAT_RISE_BIT && !ea_prev_q && src_q[SRC_EA_BIT]) ||
                (i == STAT_FALL_BIT && ea_prev_q && !src_q[SRC_EA_BIT])) begin
               stat_q[i] <= 1'b1;
            end else if (do_write && wr_ok && aw_idx_q == IDX_STATUS &&
                         wstrb_q[0] && wdata_q[i]) begin
               stat_q[i] <= 1'b0;
            end
         end
      end
   end

   assign irq = |(stat_q & mask_q);

   // Address decode helpers
   assign aw_in_range = (s_axi_awaddr[ADDR_W-1:IDX_W+2] == '0);
   assign ar_in_range = (s_axi_araddr[ADDR_W-1:IDX_W+2] == '0);
   assign ar_idx = s_axi_araddr[IDX_W+1:2];

   // Write handshakes
   assign s_axi_awready = ce & ~aw_hold_q & ~bvalid_q;
   assign s_axi_wready = ce & ~w_hold_q & ~bvalid_q;
   assign aw_fire = s_axi_awvalid & s_axi_awready;
   assign w_fire = s_axi_wvalid & s_axi_wready;
   assign do_write = ce & aw_hold_q & w_hold_q & ~bvalid_q;
   // Writable register map
   always_comb begin
      case (aw_idx_q)
         IDX_CONFIG, IDX_SOURCE, IDX_THRESH, IDX_DEBOUNCE,
         IDX_IRQ_EN, IDX_IRQ_ROUTE, IDX_STATUS, IDX_MASK,
         IDX_THR_X, IDX_THR_Y, IDX_THR_Z: wr_ok = aw_ok_q;
         default: wr_ok = 1'b0;
      endcase
   end

   // Capture address and data in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_q <= 1'b0;
         aw_idx_q <= '0;
         aw_ok_q <= 1'b0;
         w_hold_q <= 1'b0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end else if (ce) begin
         if (aw_fire) begin
            aw_hold_q <= 1'b1;
            aw_idx_q <= s_axi_awaddr[IDX_W+1:2];
            aw_ok_q <= aw_in_range;
         end else if (do_write) begin
            aw_hold_q <= 1'b0;
         end
         if (w_fire) begin
            w_hold_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end else if (do_write) begin
            w_hold_q <= 1'b0;
         end
      end
   end

   // Write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else if (ce) begin
         if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   // Software-written registers, byte lanes honoured
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_q <= CFG_RST;
         ths_q <= THS_RST;
         deb_limit_q <= DEB_RST;
         irq_en_q <= 1'b0;
         irq_route_q <= 1'b0;
         mask_q <= STAT_RST;
         for (int i = 0; i < NAXES; i++) begin
            thr_q[i] <= THR_RST;
         end
      end else if (do_write && wr_ok) begin
         case (aw_idx_q)
            IDX_CONFIG: if (wstrb_q[0]) cfg_q <= wdata_q[7:0];
            IDX_THRESH: if (wstrb_q[0]) ths_q <= wdata_q[7:0];
            IDX_DEBOUNCE: if (wstrb_q[0]) deb_limit_q <= wdata_q[7:0];
            IDX_IRQ_EN: if (wstrb_q[0]) irq_en_q <= wdata_q[0];
            IDX_IRQ_ROUTE: if (wstrb_q[0]) irq_route_q <= wdata_q[0];
            IDX_MASK: if (wstrb_q[0]) mask_q <= wdata_q[STAT_W-1:0];
            IDX_THR_X, IDX_THR_Y, IDX_THR_Z: begin
               for (int i = 0; i < NAXES; i++) begin
                  if (aw_idx_q == IDX_THR_X + 8'(2 * i)) begin
                     if (wstrb_q[0]) thr_q[i][7:0] <= wdata_q[7:0];
                     if (wstrb_q[1]) thr_q[i][15:8] <= wdata_q[15:8];
                  end
               end
            end
            default: begin
               // Source writes change nothing here
            end
         endcase
      end
   end

   // Read mux
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_ok = ar_in_range;
      case (ar_idx)
         IDX_CONFIG: rd_word[7:0] = cfg_q;
         IDX_SOURCE: rd_word[7:0] = src_view;
         IDX_THRESH: rd_word[7:0] = ths_q;
         IDX_DEBOUNCE: rd_word[7:0] = deb_limit_q;
         IDX_IRQ_EN: rd_word[0] = irq_en_q;
         IDX_IRQ_ROUTE: rd_word[0] = irq_route_q;
         IDX_STATUS: rd_word[STAT_W-1:0] = stat_q;
         IDX_MASK: rd_word[STAT_W-1:0] = mask_q;
         IDX_THR_X: rd_word[15:0] = thr_q[0];
         IDX_THR_Y: rd_word[15:0] = thr_q[1];
         IDX_THR_Z: rd_word[15:0] = thr_q[2];
         default: rd_ok = 1'b0;
      endcase
   end

   // Read channel
   assign s_axi_arready = ce & ~rvalid_q;
   assign ar_fire = s_axi_arvalid & s_axi_arready;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= RESP_OKAY;
      end else if (ce) begin
         if (ar_fire) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_ok ? rd_word : 32'h0000_0000;
            rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
endmodule // ffe_top

// ===== verification/ffe_top_sva.sv
`timescale 1ns/1ns
module ffe_top_sva (
   // Clock and control
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic sample_valid,
   // Bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // Event outputs
   input wire logic event_active_flag,
   input wire logic int1_o,
   input wire logic int2_o
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Active flag moves only on a sample or a source read
   flag_hold_a: assert property (
      ce && !sample_valid && !(s_axi_arvalid && s_axi_arready)
      |=> $stable(event_active_flag)) else $error("flag moved alone");
   // Interrupt pins follow the active flag one cycle later
   int_excl_a: assert property (!(int1_o && int2_o))
      else $error("both pins high");
   int1_src_a: assert property (
      int1_o |-> $past(event_active_flag)) else $error("int1 without flag");
   int2_src_a: assert property (
      int2_o |-> $past(event_active_flag)) else $error("int2 without flag");
   // Bus answers and holds
   wr_resp_a: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("late write response");
   rd_resp_a: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid) else $error("late read data");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
   ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
endmodule // ffe_top_sva

bind ffe_top ffe_top_sva u_sva (.aclk, .aresetn, .ce, .sample_valid,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
   .event_active_flag, .int1_o, .int2_o);

// ===== verification/tb_top.sv
`timescale 1ns/1ns
module tb_top import ffe_pkg::*; ;
   // Stimulus
   logic aclk = 0, aresetn = 0, ce = 1, sample_valid = 0;
   logic [ACC_W-1:0] accel_x = 0, accel_y = 0, accel_z = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0;
   logic [31:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wdata = 0;
   // Design outputs and captured answers
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, event_active_flag, int1_o, int2_o, irq;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [31:0] s_axi_rdata, d;
   int n_mismatch = 0, num_checks = 0;
   localparam logic [31:0] CF = 4 * IDX_CONFIG, SR = 4 * IDX_SOURCE;
   localparam logic [31:0] TH = 4 * IDX_THRESH, DB = 4 * IDX_DEBOUNCE;
   localparam logic [31:0] ST = 4 * IDX_STATUS, MK = 4 * IDX_MASK;
   localparam logic [31:0] TX = 4 * IDX_THR_X, BAD = 32'h0000_0400;
   localparam logic [13:0] P5 = 14'h1388, N5 = 14'h2c78, N6 = 14'h2890;
   localparam logic [13:0] Z0 = 14'h0000;

   ffe_top DUT (.aclk, .aresetn, .ce, .sample_valid, .accel_x, .accel_y,
      .accel_z, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
      .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
      .s_axi_wstrb(4'hf), .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
      .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0),
      .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
      .event_active_flag, .int1_o, .int2_o, .irq);

   // Clock
   initial forever #20 aclk = ~aclk;

   // Compare and count
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // Bus write, address and data offered together
   task automatic wr(input logic [31:0] a, input logic [31:0] v);
      logic ap, wp;
      ap = 1;
      wp = 1;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      while (ap || wp) begin
         @(posedge aclk);
         if (ap && s_axi_awready) begin
            ap = 0;
            s_axi_awvalid <= 0;
         end
         if (wp && s_axi_wready) begin
            wp = 0;
            s_axi_wvalid <= 0;
         end
      end
      while (!s_axi_bvalid) @(posedge aclk);
      s_axi_bready <= 1;
      @(posedge aclk);
      r = s_axi_bresp;
      s_axi_bready <= 0;
   endtask

   // Bus read, ready raised late to exercise holding
   task automatic rd(input logic [31:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1;
      @(posedge aclk);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 0;
   endtask

   task automatic rc(input logic [31:0] a, input logic [31:0] e);
      rd(a);
      chk(d, e);
   endtask

   // One sample, source visible when the task returns
   task automatic smp(input logic [13:0] x, input logic [13:0] y,
         input logic [13:0] z);
      accel_x <= x;
      accel_y <= y;
      accel_z <= z;
      sample_valid <= 1;
      @(posedge aclk);
      sample_valid <= 0;
      @(posedge aclk);
   endtask

   // Debounce run: idle, two hits, a miss, two hits
   task automatic dbr(input logic [31:0] th, input logic [31:0] e);
      wr(TH, th);
      smp(Z0, Z0, Z0);
      for (int i = 0; i < 5; i++) begin
         smp(i == 2 ? Z0 : P5, Z0, Z0);
      end
      rc(SR, e);
   endtask

   task automatic end_sim;
      $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Watchdog
   initial begin
      repeat (6000) @(posedge aclk);
      n_mismatch++;
      end_sim;
   end

   // Main sequence
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      rc(CF, 0);
      rc(SR, 0);
      rd(BAD);
      chk(r, RESP_SLVERR);
      wr(BAD, 8'hff);
      chk(r, RESP_SLVERR);
      // Motion, real time
      wr(TH, 8'h10);
      wr(CF, 8'h78);
      smp(P5, Z0, Z0);
      rc(SR, 8'h82);
      smp(N5, Z0, Z0);
      rc(SR, 8'h83);
      chk(event_active_flag, 1);
      smp(Z0, Z0, N6);
      rc(SR, 8'hb0);
      // Z disabled after its event: stored Z bits read as zero
      wr(CF, 8'h58);
      rc(SR, 8'h80);
      smp(Z0, Z0, Z0);
      rc(SR, 0);
      // Only X enabled
      wr(CF, 8'h48);
      smp(Z0, 14'h1770, Z0);
      rc(SR, 0);
      smp(N5, N6, Z0);
      rc(SR, 8'h83);
      // Free-fall, all axes low
      wr(CF, 8'h38);
      smp(14'h0064, 14'h3f9c, Z0);
      rc(SR, 8'hae);
      smp(P5, 14'h0064, Z0);
      rc(SR, 8'h28);
      // Latched motion, held then cleared by reading
      wr(CF, 8'hf8);
      smp(P5, Z0, Z0);
      smp(Z0, Z0, N6);
      rc(SR, 8'h82);
      rc(SR, 0);
      wr(SR, 8'hff);
      chk(r, RESP_OKAY);
      rc(SR, 0);
      // Per-axis thresholds
      wr(CF, 8'h78);
      wr(TX, 16'h8100);
      wr(TX + 8, 16'h1f00);
      wr(TX + 16, 16'h1f00);
      smp(14'h012c, Z0, Z0);
      rc(SR, 8'h82);
      wr(TX, 0);
      // Debounce, decrement then clear mode
      wr(DB, 8'h03);
      dbr(8'h10, 8'h82);
      dbr(8'h90, 8'h02);
      wr(DB, 0);
      wr(TH, 8'h10);
      smp(Z0, Z0, Z0);
      // Interrupt routing, status, mask
      wr(ST, 8'h03);
      rc(ST, 0);
      wr(MK, 8'h03);
      wr(4 * IDX_IRQ_EN, 1);
      wr(4 * IDX_IRQ_ROUTE, 1);
      smp(P5, Z0, Z0);
      rc(ST, 8'h01);
      chk({irq, int1_o, int2_o}, 3'h6);
      wr(4 * IDX_IRQ_ROUTE, 0);
      chk({irq, int1_o, int2_o}, 3'h5);
      wr(MK, 0);
      chk(irq, 0);
      wr(MK, 8'h03);
      chk(irq, 1);
      wr(ST, 8'h01);
      chk(irq, 0);
      smp(Z0, Z0, Z0);
      rc(ST, 8'h02);
      chk(irq, 1);
      wr(ST, 8'h02);
      chk(irq, 0);
      // Clock enable low: a sample offered then is not taken
      ce <= 0;
      smp(P5, Z0, Z0);
      ce <= 1;
      rc(SR, 0);
      end_sim;
   end
endmodule // tb_top
